//--- sec_consts.svh
// constant values for the serial eeprom controller
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH

// ==========================================
// signature and memory organisation
`define SEC_SIGNATURE 8'hA5
`define SEC_SIG_ADDR 7'h00
`define SEC_MAC_BYTES 3'h6
`define SEC_MEM_DEPTH 128
`define SEC_ADDR_BITS 7
`define SEC_DATA_BITS 8

// ==========================================
// serial frame layout: start, opcode, address, data
`define SEC_START_BIT 1'b1
`define SEC_SOP_READ 2'h2
`define SEC_SOP_WRITE 2'h1
`define SEC_SOP_ERASE 2'h3
`define SEC_SOP_EXT 2'h0
`define SEC_XADDR_ERASE_WRITE_ENABLE_COMMAND 7'h60
`define SEC_XADDR_ERASE_WRITE_DISABLE_COMMAND 7'h00
`define SEC_XADDR_ERASE_ALL_COMMAND 7'h40
`define SEC_XADDR_WRITE_ALL_COMMAND 7'h20
`define SEC_SHORT_CLOCKS 5'd10
`define SEC_LONG_CLOCKS 5'd18

// ==========================================
// serial timing, in link clock cycles
`define SEC_HALF_BIT 3'd4
`define SEC_RISE_CNT 3'd3
`define SEC_BIT_LAST 3'd7
`define SEC_CS_GAP 3'd7

// ==========================================
// response timeout
`define SEC_TIMEOUT_MS 30
`define SEC_CLK_KHZ 20000
`define SEC_TIMEOUT_CYCLES (`SEC_TIMEOUT_MS * `SEC_CLK_KHZ)
`define SEC_TMR_BITS 20

`endif

//--- sec_pkg.sv
// types shared by the serial eeprom controller
package sec_pkg;

  // host operation codes of the command register
  typedef enum logic [2:0] {
    SEC_OP_READ = 3'h0,
    SEC_OP_ERASE_WRITE_DISABLE_COMMAND = 3'h1,
    SEC_OP_ERASE_WRITE_ENABLE_COMMAND = 3'h2,
    SEC_OP_WRITE = 3'h3,
    SEC_OP_WRITE_ALL_COMMAND = 3'h4,
    SEC_OP_ERASE = 3'h5,
    SEC_OP_ERASE_ALL_COMMAND = 3'h6,
    SEC_OP_RELOAD = 3'h7
  } sec_op_t;

  // system side sequencer, gray along idle-issue-wait-abort
  typedef enum logic [1:0] {
    SEC_S_IDLE = 2'h0,
    SEC_S_ISSUE = 2'h1,
    SEC_S_WAIT = 2'h3,
    SEC_S_ABORT = 2'h2
  } sec_sys_state_t;

  // link side serial engine, gray along the usual path
  typedef enum logic [2:0] {
    SEC_L_IDLE = 3'h0,
    SEC_L_SHIFT = 3'h1,
    SEC_L_GAP = 3'h3,
    SEC_L_POLL = 3'h2,
    SEC_L_END = 3'h6
  } sec_link_state_t;

endpackage

//--- sec_ctrl.sv
// serial eeprom controller: address auto-load and host operations
// Functional notes
// [RQ1] at reset read address 00h, expect A5h
// [RQ2] on match load six bytes into address
// [RQ3] set address-loaded flag after sixth byte
// [RQ4] bad signature stops load, address untouched
// [RQ5] reload repeats check; flag only on success
// [RQ6] host waits until reset load finished
// [RQ7] host writes data before write command
// [RQ8] host sets busy, controller clears when done
// [RQ9] read data in data register before busy clears
// [RQ10] host leaves command alone while busy
// [RQ11] no answer in 30 ms: abandon, flag timeout
// [RQ12] erase one location at address field
// [RQ13] erase-all clears whole array
// [RQ14] disable command blocks later erase and write
// [RQ15] host enables erase/write before modifying
// [RQ16] read fetches addressed byte into data register
// [RQ17] write stores data register at address field
// [RQ18] write-all stores data register everywhere
// [RQ19] ten or eighteen serial clocks per operation
// [RQ20] memory of 128 eight-bit locations
// [RQ21] disabled interface hands pins to alternates
// [RQ22] start, opcode, address, data; derived serial clock
`timescale 1ns/1ps
`include "sec_consts.svh"

module sec_ctrl #(
  parameter int TIMEOUT_CYCLES = `SEC_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic soft_reset,
  input wire logic cmd_start,
  input wire sec_pkg::sec_op_t operation_code_field,
  input wire logic [6:0] target_location_field,
  input wire logic data_write,
  input wire logic [7:0] data_write_value,
  input wire logic timeout_clear,
  output logic operation_busy_bit,
  output logic response_timeout_flag,
  output logic address_loaded_flag,
  output logic [7:0] eeprom_data_register,
  output logic [47:0] station_address,
  input wire logic iface_enable,
  input wire logic alt_clock_value,
  input wire logic alt_data_value,
  output logic serial_memory_clock_pin,
  output logic serial_memory_select,
  input wire logic serial_memory_data_in,
  output logic serial_memory_data_out,
  output logic serial_memory_data_oe
);
  import sec_pkg::*;

  // ==========================================
  // elaboration checks: the timer must hold the whole span
  if (TIMEOUT_CYCLES < 1 ||
      TIMEOUT_CYCLES >= (1 << `SEC_TMR_BITS)) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end

  localparam logic [`SEC_TMR_BITS-1:0] TMR_LAST =
    `SEC_TMR_BITS'(TIMEOUT_CYCLES - 1);

  // ==========================================
  // system domain declarations
  sec_sys_state_t state_reg;
  sec_op_t op_reg;
  logic [6:0] addr_reg;
  logic busy_reg;
  logic reload_pend_reg;
  logic load_mode_reg;
  logic [2:0] load_idx_reg;
  logic timeout_reg;
  logic loaded_reg;
  logic [7:0] data_reg;
  logic [47:0] mac_reg;
  logic [`SEC_TMR_BITS-1:0] tmr_reg;
  logic req_tgl_reg;
  logic abort_reg;
  logic [17:0] frame_reg;
  logic long_reg;
  logic poll_reg;
  logic read_reg;
  logic done_s1, done_s2, done_s3;
  logic done_seen;
  logic [7:0] rdata_reg;

  // ==========================================
  // link domain declarations
  sec_link_state_t lk_state_reg;
  logic lrst_s1, lrst_s2;
  logic req_s1, req_s2, req_s3;
  logic abort_s1, abort_s2;
  logic din_s1, din_s2;
  logic req_edge;
  logic [2:0] lk_cnt_reg;
  logic [4:0] lk_bit_reg;
  logic [17:0] lk_shift_reg;
  logic lk_cs_reg;
  logic lk_sclk_reg;
  logic lk_oe_reg;
  logic done_tgl_reg;
  logic [4:0] lk_last_bit;

  // ==========================================
  // frame building for the next link request
  sec_op_t issue_op;
  logic [6:0] issue_addr;
  logic [1:0] issue_sop;
  logic [6:0] issue_field;
  logic issue_long;
  logic issue_poll;
  logic issue_read;
  logic [17:0] issue_frame;
  logic host_take;
  logic start_load;
  logic sig_ok;
  logic load_last;

  // autoload always issues reads of successive locations
  assign issue_op = load_mode_reg ? SEC_OP_READ : op_reg;
  // [RQ20] seven-bit location, 128 bytes
  assign issue_addr = load_mode_reg ? {4'h0, load_idx_reg} : addr_reg;
  assign issue_frame = {`SEC_START_BIT, issue_sop, issue_field, data_reg};
  assign host_take = cmd_start && !busy_reg;
  assign start_load = reload_pend_reg ||
    (busy_reg && op_reg == SEC_OP_RELOAD);
  // [RQ1] signature compare
  assign sig_ok = rdata_reg == `SEC_SIGNATURE;
  assign load_last = load_idx_reg == `SEC_MAC_BYTES;
  assign done_seen = done_s2 ^ done_s3;

  // opcode, address field and clock count per operation
  always_comb begin
    issue_sop = `SEC_SOP_EXT;
    issue_field = issue_addr;
    issue_long = 1'b0;
    issue_poll = 1'b0;
    issue_read = 1'b0;
    case (issue_op)
      // [RQ16] read location
      SEC_OP_READ: begin
        issue_sop = `SEC_SOP_READ;
        issue_long = 1'b1;
        issue_read = 1'b1;
      end
      // [RQ14] erase/write disable
      SEC_OP_ERASE_WRITE_DISABLE_COMMAND: issue_field = `SEC_XADDR_ERASE_WRITE_DISABLE_COMMAND;
      SEC_OP_ERASE_WRITE_ENABLE_COMMAND: issue_field = `SEC_XADDR_ERASE_WRITE_ENABLE_COMMAND;
      // [RQ17] write location
      SEC_OP_WRITE: begin
        issue_sop = `SEC_SOP_WRITE;
        issue_long = 1'b1;
        issue_poll = 1'b1;
      end
      // [RQ18] write all
      SEC_OP_WRITE_ALL_COMMAND: begin
        issue_field = `SEC_XADDR_WRITE_ALL_COMMAND;
        issue_long = 1'b1;
        issue_poll = 1'b1;
      end
      // [RQ12] erase location
      SEC_OP_ERASE: begin
        issue_sop = `SEC_SOP_ERASE;
        issue_poll = 1'b1;
      end
      // [RQ13] erase all
      SEC_OP_ERASE_ALL_COMMAND: begin
        issue_field = `SEC_XADDR_ERASE_ALL_COMMAND;
        issue_poll = 1'b1;
      end
      default: issue_sop = `SEC_SOP_EXT;
    endcase
  end

  // ==========================================
  // system sequencer
  // done toggle from the link domain, two stages then edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      done_s1 <= done_tgl_reg;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  // host command capture and the main state flow
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= SEC_S_IDLE;
      busy_reg <= 1'b1;
      reload_pend_reg <= 1'b1;
      load_mode_reg <= 1'b0;
      load_idx_reg <= 3'h0;
      op_reg <= SEC_OP_READ;
      addr_reg <= 7'h00;
      abort_reg <= 1'b0;
      tmr_reg <= '0;
    end else begin
      // [RQ8] host sets busy to launch
      if (host_take) begin
        busy_reg <= 1'b1;
        op_reg <= operation_code_field;
        addr_reg <= target_location_field;
      end
      // [RQ1] soft reset repeats the autoload
      if (soft_reset) begin
        reload_pend_reg <= 1'b1;
      end
      case (state_reg)
        SEC_S_IDLE: begin
          if (start_load) begin
            // [RQ5] reload restarts at the signature
            busy_reg <= 1'b1;
            reload_pend_reg <= soft_reset;
            load_mode_reg <= 1'b1;
            load_idx_reg <= 3'h0;
            state_reg <= SEC_S_ISSUE;
          end else if (busy_reg) begin
            load_mode_reg <= 1'b0;
            state_reg <= SEC_S_ISSUE;
          end
        end
        SEC_S_ISSUE: begin
          tmr_reg <= '0;
          state_reg <= SEC_S_WAIT;
        end
        SEC_S_WAIT: begin
          if (done_seen) begin
            if (load_mode_reg && load_idx_reg == 3'h0 && !sig_ok) begin
              // [RQ4] no signature, stop loading
              load_mode_reg <= 1'b0;
              busy_reg <= 1'b0;
              state_reg <= SEC_S_IDLE;
            end else if (load_mode_reg && !load_last) begin
              // [RQ2] next address byte
              load_idx_reg <= load_idx_reg + 3'h1;
              state_reg <= SEC_S_ISSUE;
            end else begin
              // [RQ8] completion clears busy
              load_mode_reg <= 1'b0;
              busy_reg <= 1'b0;
              state_reg <= SEC_S_IDLE;
            end
          end else if (tmr_reg == TMR_LAST) begin
            // [RQ11] abandon after the timeout
            abort_reg <= 1'b1;
            state_reg <= SEC_S_ABORT;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        SEC_S_ABORT: begin
          if (done_seen) begin
            abort_reg <= 1'b0;
            load_mode_reg <= 1'b0;
            busy_reg <= 1'b0;
            state_reg <= SEC_S_IDLE;
          end
        end
        default: state_reg <= SEC_S_IDLE;
      endcase
    end
  end

  // request words held stable while the toggle crosses over
  always_ff @(posedge clk) begin
    if (rst) begin
      req_tgl_reg <= 1'b0;
      frame_reg <= '0;
      long_reg <= 1'b0;
      poll_reg <= 1'b0;
      read_reg <= 1'b0;
    end else if (state_reg == SEC_S_ISSUE) begin
      req_tgl_reg <= ~req_tgl_reg;
      frame_reg <= issue_frame;
      long_reg <= issue_long;
      poll_reg <= issue_poll;
      read_reg <= issue_read;
    end
  end

  // timeout and loaded flags; a set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end else begin
      // [RQ11] timeout flag, sticky until cleared
      if (state_reg == SEC_S_WAIT && !done_seen && tmr_reg == TMR_LAST) begin
        timeout_reg <= 1'b1;
      end else if (timeout_clear) begin
        timeout_reg <= 1'b0;
      end
      // [RQ3] flag after the sixth byte; [RQ5] cleared on reload
      if (state_reg == SEC_S_WAIT && done_seen && load_mode_reg &&
          load_last) begin
        loaded_reg <= 1'b1;
      end else if (state_reg == SEC_S_IDLE && start_load) begin
        loaded_reg <= 1'b0;
      end
    end
  end

  // data register: read completion wins over a host write
  always_ff @(posedge clk) begin
    if (rst) begin
      data_reg <= 8'h00;
    end else if (state_reg == SEC_S_WAIT && done_seen && !load_mode_reg &&
                 op_reg == SEC_OP_READ) begin
      // [RQ9] data lands with the busy clear
      data_reg <= rdata_reg;
    end else if (data_write) begin
      data_reg <= data_write_value;
    end
  end

  // [RQ2] one address byte per load step, byte 0 first
  generate
    for (genvar i = 0; i < 6; i++) begin : g_mac
      always_ff @(posedge clk) begin
        if (rst) begin
          mac_reg[i*8 +: 8] <= 8'h00;
        end else if (state_reg == SEC_S_WAIT && done_seen && load_mode_reg &&
                     load_idx_reg == 3'(i + 1)) begin
          mac_reg[i*8 +: 8] <= rdata_reg;
        end
      end
    end
  endgenerate

  assign operation_busy_bit = busy_reg;
  assign response_timeout_flag = timeout_reg;
  assign address_loaded_flag = loaded_reg;
  assign eeprom_data_register = data_reg;
  assign station_address = mac_reg;

  // ==========================================
  // link domain synchronisers
  always_ff @(posedge link_clk) begin
    lrst_s1 <= rst;
    lrst_s2 <= lrst_s1;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_s2) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      abort_s1 <= 1'b0;
      abort_s2 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      req_s1 <= req_tgl_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      abort_s1 <= abort_reg;
      abort_s2 <= abort_s1;
      din_s1 <= serial_memory_data_in;
      din_s2 <= din_s1;
    end
  end

  assign req_edge = req_s2 ^ req_s3;
  // [RQ19] ten or eighteen clocks per frame
  assign lk_last_bit = long_reg ? (`SEC_LONG_CLOCKS - 5'd1)
                                : (`SEC_SHORT_CLOCKS - 5'd1);

  // ==========================================
  // serial engine on the link clock
  // [RQ22] start, opcode, address, data, shifted msb first
  always_ff @(posedge link_clk) begin
    if (lrst_s2) begin
      lk_state_reg <= SEC_L_IDLE;
      lk_cnt_reg <= 3'h0;
      lk_bit_reg <= 5'h00;
      lk_shift_reg <= '0;
      lk_cs_reg <= 1'b0;
      lk_sclk_reg <= 1'b0;
      lk_oe_reg <= 1'b0;
      rdata_reg <= 8'h00;
      done_tgl_reg <= 1'b0;
    end else begin
      lk_cnt_reg <= lk_cnt_reg + 3'h1;
      case (lk_state_reg)
        SEC_L_IDLE: begin
          lk_cnt_reg <= 3'h0;
          lk_bit_reg <= 5'h00;
          if (req_edge) begin
            lk_shift_reg <= frame_reg;
            lk_cs_reg <= 1'b1;
            lk_oe_reg <= 1'b1;
            lk_state_reg <= SEC_L_SHIFT;
          end
        end
        SEC_L_SHIFT: begin
          if (abort_s2) begin
            lk_state_reg <= SEC_L_END;
          end else if (lk_cnt_reg == `SEC_RISE_CNT) begin
            lk_sclk_reg <= 1'b1;
          end else if (lk_cnt_reg == `SEC_BIT_LAST) begin
            lk_sclk_reg <= 1'b0;
            lk_shift_reg <= {lk_shift_reg[16:0], 1'b0};
            lk_bit_reg <= lk_bit_reg + 5'h01;
            // [RQ16] read data sampled after each late rising edge
            if (read_reg && lk_bit_reg >= `SEC_SHORT_CLOCKS) begin
              rdata_reg <= {rdata_reg[6:0], din_s2};
            end
            // release the data line only after the last address bit
            if (read_reg && lk_bit_reg == `SEC_SHORT_CLOCKS - 5'd1) begin
              lk_oe_reg <= 1'b0;
            end
            if (lk_bit_reg == lk_last_bit) begin
              lk_cs_reg <= 1'b0;
              lk_oe_reg <= 1'b0;
              lk_state_reg <= SEC_L_GAP;
            end
          end
        end
        SEC_L_GAP: begin
          if (abort_s2) begin
            lk_state_reg <= SEC_L_END;
          end else if (lk_cnt_reg == `SEC_CS_GAP) begin
            lk_cs_reg <= poll_reg;
            lk_state_reg <= poll_reg ? SEC_L_POLL : SEC_L_END;
          end
        end
        SEC_L_POLL: begin
          // [RQ11] ready shows as data high; abort ends the wait
          if (abort_s2 || (din_s2 && lk_cnt_reg == `SEC_BIT_LAST)) begin
            lk_cs_reg <= 1'b0;
            lk_state_reg <= SEC_L_END;
          end
        end
        SEC_L_END: begin
          lk_cs_reg <= 1'b0;
          lk_sclk_reg <= 1'b0;
          lk_oe_reg <= 1'b0;
          done_tgl_reg <= ~done_tgl_reg;
          lk_state_reg <= SEC_L_IDLE;
        end
        default: lk_state_reg <= SEC_L_IDLE;
      endcase
    end
  end

  // ==========================================
  // pin sharing
  // [RQ21] alternate drivers when the interface is off
  assign serial_memory_clock_pin = iface_enable ? lk_sclk_reg
                                                : alt_clock_value;
  assign serial_memory_select = iface_enable & lk_cs_reg;
  assign serial_memory_data_out = iface_enable ? lk_shift_reg[17]
                                               : alt_data_value;
  assign serial_memory_data_oe = iface_enable ? lk_oe_reg : 1'b1;

endmodule // sec_ctrl

//--- sec_ctrl_monitor.sv
// concurrent checks on the ports of the serial eeprom controller
`timescale 1ns/1ps
module sec_ctrl_monitor
  import sec_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 800
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_start,
  input wire sec_pkg::sec_op_t operation_code_field,
  input wire logic data_write,
  input wire logic timeout_clear,
  input wire logic operation_busy_bit,
  input wire logic response_timeout_flag,
  input wire logic address_loaded_flag,
  input wire logic [7:0] eeprom_data_register,
  input wire logic [47:0] station_address,
  input wire logic iface_enable,
  input wire logic alt_clock_value,
  input wire logic alt_data_value,
  input wire logic serial_memory_clock_pin,
  input wire logic serial_memory_select,
  input wire logic serial_memory_data_out,
  input wire logic serial_memory_data_oe
);
  // longest op is a timed-out poll plus the link abort
  localparam int BUSY_MAX = TIMEOUT_CYCLES + 200;
  wire busy = operation_busy_bit;
  wire tmo = response_timeout_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // named steps
  sequence host_go;
    cmd_start && !busy;
  endsequence
  sequence pins_off;
    (!iface_enable && $stable(alt_clock_value) && $stable(alt_data_value)) [*3];
  endsequence
  sequence idle_run;
    (iface_enable && !busy) [*8];
  endsequence
  // ==========================================
  // assertions
  busy_set_a: assert property (host_go |=> busy)
    else $error("busy not raised by a start");
  busy_release_a: assert property (
    host_go ##0 (operation_code_field != SEC_OP_RELOAD)
      |-> ##[2:BUSY_MAX] !busy)
    else $error("busy never released");
  tmo_abort_a: assert property ($rose(tmo) |-> ##[0:60] !busy)
    else $error("timeout left busy set");
  tmo_sticky_a: assert property (tmo && !timeout_clear |=> tmo)
    else $error("timeout flag dropped by itself");
  tmo_clear_a: assert property (timeout_clear && !busy |=> !tmo)
    else $error("timeout flag not cleared");
  addr_hold_a: assert property (
    $changed(station_address) |-> $past(busy))
    else $error("station address changed while idle");
  load_drop_a: assert property (
    host_go ##0 (operation_code_field == SEC_OP_RELOAD)
      |-> ##[1:3] !address_loaded_flag)
    else $error("loaded flag kept through reload");
  load_done_a: assert property (
    $rose(address_loaded_flag) |-> $past(busy) && !busy)
    else $error("loaded flag set outside completion");
  data_hold_a: assert property (
    $changed(eeprom_data_register) |-> $past(data_write) || $past(busy))
    else $error("data register changed without cause");
  pins_alt_a: assert property (pins_off |->
    !serial_memory_select && serial_memory_data_oe &&
    serial_memory_data_out == alt_data_value &&
    serial_memory_clock_pin == alt_clock_value)
    else $error("disabled pins not handed to alternates");
  select_idle_a: assert property (idle_run |-> !serial_memory_select)
    else $error("memory selected while idle");
endmodule // sec_ctrl_monitor

//--- sec_eeprom_model.sv
// behavioural three-wire serial eeprom of 128 bytes
`timescale 1ns/1ps
module sec_eeprom_model (
  input wire logic sk,
  input wire logic cs,
  input wire logic di,
  input wire logic mute,
  output logic drv,
  output logic dval
);
  logic [7:0] mem [0:127];
  logic [17:0] sh;
  logic [1:0] op;
  logic [6:0] a;
  logic erase_write_enable_command, rdy, stat, rd_drv, rd_val, er;
  int cnt, bits;
  // 128 bytes, erase/write disabled at power-up
  initial begin
    for (int i = 0; i < 128; i++)
      mem[i] = (i == 0) ? 8'hA5 : (i < 7) ? 8'h11 * i[7:0] : 8'hFF;
    {erase_write_enable_command, stat, rd_drv, rd_val} = 4'h0;
    rdy = 1;
    cnt = 0;
    bits = 0;
  end
  // ready status from select until the first clock, read data otherwise
  assign drv = stat || rd_drv;
  assign dval = stat ? rdy : rd_val;
  // a muted device stays not ready after a program cycle until unmuted
  always @(posedge cs) begin
    cnt = 0;
    stat = 1;
  end
  always @(negedge mute) rdy = 1;
  // start, opcode, address in; read data out msb first
  always @(posedge sk) begin
    if (cs) begin
      stat = 0;
      if (cnt < 10 || op != 2'b10) sh = {sh[16:0], di};
      if (cnt == 9) begin
        op = sh[8:7];
        a = sh[6:0];
      end
      if (cnt >= 10 && cnt < 18 && op == 2'b10) begin
        rd_drv <= #10 1'b1;
        rd_val <= #10 mem[a][17 - cnt];
      end
      cnt = cnt + 1;
    end
  end
  always @(negedge cs) begin
    rd_drv = 0;
    stat = 0;
    if (cnt > 0) bits = cnt;
    er = op == 2'b11 || (op == 2'b00 && a[6:5] == 2'b10);
    if (op == 2'b00 && a[6:5] == 2'b11 && cnt == 10) erase_write_enable_command = 1;
    else if (op == 2'b00 && a[6:5] == 2'b00 && cnt == 10) erase_write_enable_command = 0;
    else if (op != 2'b10 && erase_write_enable_command && cnt == (er ? 10 : 18)) begin
      for (int i = 0; i < 128; i++)
        if (op == 2'b00 || i == a) mem[i] = er ? 8'hFF : sh[7:0];
      rdy = 0;
      if (!mute) rdy <= #2000 1'b1;
    end
  end
endmodule // sec_eeprom_model

//--- serial_eeprom_controller_tb.sv
// self-checking bench for the serial eeprom controller
`timescale 1ns/1ps
module serial_eeprom_controller_tb;
  import sec_pkg::*;
  localparam int TIMEOUT_CYCLES = 800;
  logic clk = 0;
  logic link_clk = 0;
  logic rst = 1;
  logic soft_reset = 0, cmd_start = 0, data_write = 0, timeout_clear = 0;
  logic iface_enable = 1, alt_clock_value = 0, alt_data_value = 0, mute = 0;
  sec_op_t operation_code_field = SEC_OP_READ;
  logic [6:0] target_location_field = 7'h00;
  logic [7:0] data_write_value = 8'h00;
  logic operation_busy_bit, response_timeout_flag, address_loaded_flag;
  logic [7:0] eeprom_data_register;
  logic [47:0] station_address;
  logic serial_memory_clock_pin, serial_memory_select, dio, mdrv, mval;
  logic serial_memory_data_out, serial_memory_data_oe;
  int mismatches = 0;
  int cmp_count = 0;
  // clocks of unrelated phase
  always #25 clk = ~clk;
  always #40 link_clk = ~link_clk;
  // data wire: the driving side wins, a released line shows the inverse
  assign dio = serial_memory_data_oe ? serial_memory_data_out
                                     : (mdrv ? mval : ~mval);
  sec_ctrl #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) dut (
    .clk, .rst, .link_clk, .soft_reset, .cmd_start, .operation_code_field,
    .target_location_field, .data_write, .data_write_value, .timeout_clear,
    .operation_busy_bit, .response_timeout_flag, .address_loaded_flag,
    .eeprom_data_register, .station_address, .iface_enable,
    .alt_clock_value, .alt_data_value, .serial_memory_clock_pin,
    .serial_memory_select, .serial_memory_data_in(dio),
    .serial_memory_data_out, .serial_memory_data_oe
  );
  sec_eeprom_model eep (
    .sk(serial_memory_clock_pin), .cs(serial_memory_select), .di(dio),
    .mute(mute), .drv(mdrv), .dval(mval)
  );
  // ==========================================
  // access tasks
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (operation_busy_bit !== 1'b0 && n < 4000) begin
      tick();
      n++;
    end
    if (n == 4000) mismatches++;
  endtask
  // fields change only while idle and stay put until the next start
  task automatic run(input sec_op_t c, input logic [6:0] a);
    operation_code_field = c;
    target_location_field = a;
    cmd_start = 1;
    tick();
    cmd_start = 0;
    idle();
  endtask
  task automatic wr(input logic [7:0] v);
    data_write = 1;
    data_write_value = v;
    tick();
    data_write = 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    run(SEC_OP_READ, a);
    chk(eeprom_data_register, e);
    chk(eep.bits, 18);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  initial begin
    // reset long enough for four link edges too
    repeat (8) tick();
    rst = 0;
    idle();
    chk(address_loaded_flag, 1);
    chk(station_address, 48'h665544332211);
    rd(7'h01, 8'h11);
    wr(8'h3C);
    run(SEC_OP_WRITE, 7'h09);
    rd(7'h09, 8'hFF);
    run(SEC_OP_ERASE_WRITE_ENABLE_COMMAND, 7'h00);
    chk(eep.bits, 10);
    wr(8'h3C);
    run(SEC_OP_WRITE, 7'h09);
    rd(7'h09, 8'h3C);
    run(SEC_OP_ERASE, 7'h09);
    chk(eep.bits, 10);
    rd(7'h09, 8'hFF);
    wr(8'h5A);
    run(SEC_OP_WRITE_ALL_COMMAND, 7'h00);
    chk(eep.bits, 18);
    rd(7'h00, 8'h5A);
    rd(7'h7F, 8'h5A);
    run(SEC_OP_ERASE_ALL_COMMAND, 7'h00);
    rd(7'h40, 8'hFF);
    run(SEC_OP_ERASE_WRITE_DISABLE_COMMAND, 7'h00);
    wr(8'h77);
    run(SEC_OP_WRITE, 7'h7F);
    rd(7'h7F, 8'hFF);
    // blank signature: reload fails, address kept
    run(SEC_OP_RELOAD, 7'h00);
    chk(address_loaded_flag, 0);
    chk(station_address, 48'h665544332211);
    eep.mem[0] = 8'hA5;
    for (int i = 1; i < 7; i++) eep.mem[i] = 8'h80 + i[7:0];
    run(SEC_OP_RELOAD, 7'h00);
    chk(address_loaded_flag, 1);
    chk(station_address, 48'h868584838281);
    // soft reset repeats the load
    eep.mem[6] = 8'hC3;
    soft_reset = 1;
    tick();
    soft_reset = 0;
    repeat (4) tick();
    idle();
    chk(station_address, 48'hC38584838281);
    chk(response_timeout_flag, 0);
    // muted device: erase times out
    mute = 1;
    run(SEC_OP_ERASE_WRITE_ENABLE_COMMAND, 7'h00);
    run(SEC_OP_ERASE, 7'h02);
    chk(response_timeout_flag, 1);
    mute = 0;
    timeout_clear = 1;
    tick();
    timeout_clear = 0;
    tick();
    chk(response_timeout_flag, 0);
    // disabled interface hands pins to the alternates
    iface_enable = 0;
    for (int v = 0; v < 4; v++) begin
      {alt_clock_value, alt_data_value} = v[1:0];
      repeat (4) tick();
      chk({serial_memory_clock_pin, serial_memory_select,
           serial_memory_data_out, serial_memory_data_oe},
          {v[1], 1'b0, v[0], 1'b1});
    end
    iface_enable = 1;
    final_report();
  end
  // watchdog well past the expected run of some 11000 cycles
  initial begin
    #2500000;
    mismatches++;
    final_report();
  end
endmodule // serial_eeprom_controller_tb

bind sec_ctrl sec_ctrl_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (
  .clk, .rst, .cmd_start, .operation_code_field, .data_write,
  .timeout_clear, .operation_busy_bit, .response_timeout_flag,
  .address_loaded_flag, .eeprom_data_register, .station_address,
  .iface_enable, .alt_clock_value, .alt_data_value,
  .serial_memory_clock_pin, .serial_memory_select,
  .serial_memory_data_out, .serial_memory_data_oe
);
